// file: include/abu_defines.svh
// Constants of the address breakpoint unit: register indices, field positions, reset values.
// Assumes that the includer places the registers at byte address four times the index.
`ifndef ABU_DEFINES_SVH
`define ABU_DEFINES_SVH

// Register indices; the byte address on the bus is four times the index.
`define ABU_IDX_MEMORY_CONTROL          8'h95
`define ABU_IDX_BREAKPOINT_CONTROL      8'hA9
`define ABU_IDX_BREAKPOINT_ADDRESS_LOW  8'hAA
`define ABU_IDX_BREAKPOINT_ADDRESS_HIGH 8'hAB
`define ABU_IDX_IRQ_STATUS              8'hB0
`define ABU_IDX_IRQ_MASK                8'hB1

// Field positions.
`define ABU_BIT_COMPARATOR_SELECT       7
`define ABU_BIT_HIT_FLAG                7
`define ABU_BIT_SPACE_SELECT_PROGRAM    1
`define ABU_BIT_COMPARE_ENABLE          0

// Reset values.
`define ABU_RST_MEMORY_CONTROL          8'h00
`define ABU_RST_BREAKPOINT_CONTROL      8'h00
`define ABU_RST_TARGET_ADDRESS          16'h0000
`define ABU_RST_IRQ_STATUS              2'h0
`define ABU_RST_IRQ_MASK                2'h0

// Shape of the bus word and of the register index.
`define ABU_BUS_DATA_W                  32
`define ABU_IDX_LSB                     2
`define ABU_IDX_MSB                     9

`endif

// file: include/abu_pkg.sv
// Types shared by the address breakpoint unit and its comparators.
// Assumes nothing of its surroundings.
package abu_pkg;

  // A byte as seen in the register file.
  typedef logic [7:0] abu_byte_t;

  // A 16-bit memory address watched by a comparator.
  typedef logic [15:0] abu_addr_t;

  // Memory space that a comparator watches.
  typedef enum logic {
    ABU_SPACE_DATA,
    ABU_SPACE_PROGRAM
  } abu_space_t;

endpackage : abu_pkg

// file: include/abu_cmp_if.sv
// Carrier between the register file and one breakpoint comparator.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
`default_nettype none

interface abu_cmp_if;
  // Write strobes and data from the register file.
  logic                wr_addr_low;
  logic                wr_addr_high;
  logic                wr_control;
  logic                clear_hit;
  abu_pkg::abu_byte_t  wdata;
  // State reported back by the comparator.
  abu_pkg::abu_addr_t  target;
  abu_pkg::abu_space_t space;
  logic                enable;
  logic                hit;
  logic                match;

  modport ctrl (
    output wr_addr_low, wr_addr_high, wr_control, clear_hit, wdata,
    input  target, space, enable, hit, match
  );

  modport cmp (
    input  wr_addr_low, wr_addr_high, wr_control, clear_hit, wdata,
    output target, space, enable, hit, match
  );
endinterface : abu_cmp_if

`default_nettype wire

// file: src/abu_comparator.sv
// One breakpoint comparator: target address, space, enable and sticky hit flag.
// Assumes access strobes on the core buses are synchronous to clk_in.
`timescale 1ns/10ps
`default_nettype none
`include "abu_defines.svh"

module abu_comparator (
  // Clock and reset.
  input  wire logic                clk_in,
  input  wire logic                reset_in,
  // Register file side.
  abu_cmp_if.cmp                   cfg,
  // Core buses.
  input  wire logic                prog_access_in,
  input  wire abu_pkg::abu_addr_t  prog_addr_in,
  input  wire logic                data_access_in,
  input  wire abu_pkg::abu_addr_t  data_addr_in
);

  abu_pkg::abu_addr_t  target_q;
  abu_pkg::abu_space_t space_q;
  logic                enable_q;
  logic                hit_q;

  // Full 16-bit equality of an access against the stored target.
  function automatic logic addr_hit(input logic access, input abu_pkg::abu_addr_t addr,
                                    input abu_pkg::abu_addr_t tgt);
    addr_hit = access && (addr == tgt);
  endfunction : addr_hit

  // Match on the chosen space only; prefetches count like any other fetch.
  always_comb begin
    if (space_q == abu_pkg::ABU_SPACE_PROGRAM) begin
      cfg.match = enable_q && addr_hit(prog_access_in, prog_addr_in, target_q);
    end else begin
      cfg.match = enable_q && addr_hit(data_access_in, data_addr_in, target_q);
    end
  end

  // Target address bytes, low and high written separately.
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      target_q <= `ABU_RST_TARGET_ADDRESS;
    end else if (cfg.wr_addr_low) begin
      target_q[7:0] <= cfg.wdata;
    end else if (cfg.wr_addr_high) begin
      target_q[15:8] <= cfg.wdata;
    end
  end

  // Space and enable bits of this comparator.
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      space_q  <= abu_pkg::ABU_SPACE_DATA;
      enable_q <= 1'b0;
    end else if (cfg.wr_control) begin
      space_q  <= abu_pkg::abu_space_t'(cfg.wdata[`ABU_BIT_SPACE_SELECT_PROGRAM]);
      enable_q <= cfg.wdata[`ABU_BIT_COMPARE_ENABLE];
    end
  end

  // Sticky hit; a match in the clearing cycle keeps the flag set.
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      hit_q <= 1'b0;
    end else if (cfg.match) begin
      hit_q <= 1'b1;
    end else if (cfg.clear_hit) begin
      hit_q <= 1'b0;
    end
  end

  // State seen by the register file.
  assign cfg.target = target_q;
  assign cfg.space  = space_q;
  assign cfg.enable = enable_q;
  assign cfg.hit    = hit_q;

endmodule : abu_comparator

`default_nettype wire

// file: src/abu_top.sv
// Address breakpoint unit: two comparators, their register file and interrupts.
// Assumes an Avalon-MM master on clk_in and core access strobes synchronous to clk_in.
// Register map; each register sits in byte lane 0 at four times its index.
// Index 0x95 memory control: bit 7 comparator select, bits 6:0 plain storage.
// Index 0xA9 breakpoint control: bit 7 hit flag, bit 1 space, bit 0 enable.
// Index 0xAA and 0xAB hold the low and high target byte of the selected comparator.
// Index 0xB0 holds one event bit per comparator, and its read clears them.
// Index 0xB1 masks those event bits onto irq_out, with the same layout.
//
// Every bus request waits exactly one cycle: waitrequest is high in the first
// cycle and low in the second, and the access is taken at the edge closing it.
// A request that is held high past that edge is a new request.
//
// The target bytes are written one at a time, so an enabled comparator compares
// against a half-updated target; software should keep it disabled meanwhile.
// A hit wins over a clear, a select write and a status read in the same cycle.
// The breakpoint line has no enable or mask; the interrupt controller owns them.
`timescale 1ns/10ps
`default_nettype none
`include "abu_defines.svh"

module abu_top #(
  parameter int ADDR_W = 10
) (
  // Clock and reset.
  input  wire logic                clk_in,
  input  wire logic                reset_in,
  // Avalon-MM slave.
  input  wire logic [ADDR_W-1:0]   avs_address_in,
  input  wire logic                avs_read_in,
  input  wire logic                avs_write_in,
  input  wire logic [3:0]          avs_byteenable_in,
  input  wire logic [31:0]         avs_writedata_in,
  output logic      [31:0]         avs_readdata_out,
  output logic                     avs_waitrequest_out,
  // Core program and data buses.
  input  wire logic                prog_access_in,
  input  wire abu_pkg::abu_addr_t  prog_addr_in,
  input  wire logic                data_access_in,
  input  wire abu_pkg::abu_addr_t  data_addr_in,
  // Interrupts.
  output logic                     bp_aux_irq_out,
  output logic                     irq_out
);

  localparam int NUM_CMP = 2;

  // Bus handshake state.
  logic                ack_q;
  logic                ack_d;
  logic [31:0]         rdata_q;
  logic [31:0]         rdata_d;
  logic                req;
  logic                wr_take;
  logic                rd_take;
  logic [7:0]          idx;
  abu_pkg::abu_byte_t  wbyte;

  // Register write strobes.
  logic                wr_memctl;
  logic                wr_bpctl;
  logic                wr_low;
  logic                wr_high;
  logic                wr_mask;
  logic                rd_status;

  // Register state.
  logic                sel_q;
  logic                sel_d;
  logic [6:0]          memctl_rest_q;
  logic [6:0]          memctl_rest_d;
  logic [1:0]          status_q;
  logic [1:0]          status_d;
  logic [1:0]          mask_q;
  logic [1:0]          mask_d;

  // Per-comparator views.
  logic [NUM_CMP-1:0]  cmp_match;
  logic [NUM_CMP-1:0]  cmp_hit;
  logic [NUM_CMP-1:0]  cmp_enable;
  logic [NUM_CMP-1:0]  cmp_space;
  abu_pkg::abu_addr_t  cmp_target [NUM_CMP];
  logic                hit_any;

  // Fields of the comparator that the select bit names.
  abu_pkg::abu_addr_t  sel_target;
  logic                sel_space;
  logic                sel_enable;

  // True when the index names the given register.
  function automatic logic idx_is(input logic [7:0] cur, input logic [7:0] reg_idx);
    idx_is = (cur == reg_idx);
  endfunction : idx_is

  // True when the select bit names the given comparator.
  function automatic logic is_selected(input logic sel, input int unsigned bank);
    is_selected = (sel == 1'(bank));
  endfunction : is_selected

  // Request decode; every access waits exactly one cycle before it is taken.
  always_comb begin
    idx                 = avs_address_in[`ABU_IDX_MSB:`ABU_IDX_LSB];
    wbyte               = avs_writedata_in[7:0];
    req                 = avs_read_in | avs_write_in;
    avs_waitrequest_out = req & ~ack_q;
    ack_d               = req & ~ack_q;
    wr_take             = avs_write_in & ack_q & avs_byteenable_in[0];
    rd_take             = avs_read_in & ack_q;
  end

  // Write strobes per register; unmapped indices are ignored.
  always_comb begin
    wr_memctl = wr_take && idx_is(idx, `ABU_IDX_MEMORY_CONTROL);
    wr_bpctl  = wr_take && idx_is(idx, `ABU_IDX_BREAKPOINT_CONTROL);
    wr_low    = wr_take && idx_is(idx, `ABU_IDX_BREAKPOINT_ADDRESS_LOW);
    wr_high   = wr_take && idx_is(idx, `ABU_IDX_BREAKPOINT_ADDRESS_HIGH);
    wr_mask   = wr_take && idx_is(idx, `ABU_IDX_IRQ_MASK);
    rd_status = rd_take && idx_is(idx, `ABU_IDX_IRQ_STATUS);
  end

  // Acknowledge toggles high for one cycle in the second cycle of each request.
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= ack_d;
    end
  end

  // The two comparators, evaluated side by side every cycle.
  genvar g;
  generate
    for (g = 0; g < NUM_CMP; g++) begin : gen_cmp
      abu_cmp_if bus ();
      logic      cmp_sel;

      // This comparator is the one that software has selected.
      assign cmp_sel = is_selected(sel_q, g);

      // Only the selected comparator sees configuration writes.
      assign bus.wr_addr_low  = wr_low  && cmp_sel;
      assign bus.wr_addr_high = wr_high && cmp_sel;
      assign bus.wr_control   = wr_bpctl && cmp_sel;
      assign bus.clear_hit    = wr_bpctl && cmp_sel &&
                                wbyte[`ABU_BIT_HIT_FLAG];
      assign bus.wdata        = wbyte;

      abu_comparator u_cmp (
        .clk_in         (clk_in),
        .reset_in       (reset_in),
        .cfg            (bus.cmp),
        .prog_access_in (prog_access_in),
        .prog_addr_in   (prog_addr_in),
        .data_access_in (data_access_in),
        .data_addr_in   (data_addr_in)
      );

      assign cmp_match[g]  = bus.match;
      assign cmp_hit[g]    = bus.hit;
      assign cmp_enable[g] = bus.enable;
      assign cmp_space[g]  = bus.space;
      assign cmp_target[g] = bus.target;
    end
  endgenerate

  // Shared hit flag over both comparators.
  assign hit_any = |cmp_hit;

  // Next select; a hit overrides software and names the comparator that fired.
  always_comb begin
    sel_d = sel_q;
    if (cmp_match[0]) begin
      sel_d = 1'b0;
    end else if (cmp_match[1]) begin
      sel_d = 1'b1;
    end else if (wr_memctl) begin
      sel_d = wbyte[`ABU_BIT_COMPARATOR_SELECT];
    end
  end

  // Comparator select register.
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      sel_q <= 1'(`ABU_RST_MEMORY_CONTROL >> `ABU_BIT_COMPARATOR_SELECT);
    end else begin
      sel_q <= sel_d;
    end
  end

  // Remaining memory control bits are plain storage.
  always_comb begin
    memctl_rest_d = wr_memctl ? wbyte[6:0] : memctl_rest_q;
  end

  // Storage bits of memory control.
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      memctl_rest_q <= 7'(`ABU_RST_MEMORY_CONTROL);
    end else begin
      memctl_rest_q <= memctl_rest_d;
    end
  end

  // Next interrupt mask.
  always_comb begin
    mask_d = wr_mask ? wbyte[1:0] : mask_q;
  end

  // Interrupt mask register.
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      mask_q <= `ABU_RST_IRQ_MASK;
    end else begin
      mask_q <= mask_d;
    end
  end

  // Next event bits; a read clears only the bits it returned, so a new hit survives.
  always_comb begin
    status_d = status_q | cmp_match;
    if (rd_status) begin
      status_d = (status_q & ~rdata_q[1:0]) | cmp_match;
    end
  end

  // Sticky event bits.
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      status_q <= `ABU_RST_IRQ_STATUS;
    end else begin
      status_q <= status_d;
    end
  end

  // Fields of the selected comparator, as the registers show them.
  assign sel_target = cmp_target[sel_q];
  assign sel_space  = cmp_space[sel_q];
  assign sel_enable = cmp_enable[sel_q];

  // Read multiplexer; unmapped indices read as zero.
  always_comb begin
    rdata_d = '0;
    unique case (1'b1)
      idx_is(idx, `ABU_IDX_MEMORY_CONTROL): begin
        rdata_d[7:0] = {sel_q, memctl_rest_q};
      end
      idx_is(idx, `ABU_IDX_BREAKPOINT_CONTROL): begin
        rdata_d[`ABU_BIT_HIT_FLAG]             = hit_any;
        rdata_d[`ABU_BIT_SPACE_SELECT_PROGRAM] = sel_space;
        rdata_d[`ABU_BIT_COMPARE_ENABLE]       = sel_enable;
      end
      idx_is(idx, `ABU_IDX_BREAKPOINT_ADDRESS_LOW): begin
        rdata_d[7:0] = sel_target[7:0];
      end
      idx_is(idx, `ABU_IDX_BREAKPOINT_ADDRESS_HIGH): begin
        rdata_d[7:0] = sel_target[15:8];
      end
      idx_is(idx, `ABU_IDX_IRQ_STATUS): begin
        rdata_d[1:0] = status_q;
      end
      idx_is(idx, `ABU_IDX_IRQ_MASK): begin
        rdata_d[1:0] = mask_q;
      end
      default: begin
        rdata_d = '0;
      end
    endcase
  end

  // Read data is captured in the waiting cycle and stands while waitrequest is low.
  always_ff @(posedge clk_in or posedge reset_in) begin
    if (reset_in) begin
      rdata_q <= '0;
    end else if (avs_read_in && !ack_q) begin
      rdata_q <= rdata_d;
    end
  end

  assign avs_readdata_out = rdata_q;

  // Breakpoint line to the interrupt controller, which applies its own enable and mask.
  assign bp_aux_irq_out = hit_any;

  // Local interrupt, high while an unmasked event bit is set.
  assign irq_out = |(status_q & mask_q);

endmodule : abu_top

`default_nettype wire

// file: test/abu_checker_sva.sv
// Concurrent checks on the breakpoint unit's bus and interrupt ports.
// Assumes it is bound to abu_top and sees only that module's ports.
`timescale 1ns/10ps
`default_nettype none
`include "abu_defines.svh"

module abu_checker #(
  parameter int ADDR_W = 10
) (
  // Clock and reset.
  input wire logic               clk_in,
  input wire logic               reset_in,
  // Avalon-MM slave.
  input wire logic [ADDR_W-1:0]  avs_address_in,
  input wire logic               avs_read_in,
  input wire logic               avs_write_in,
  input wire logic [3:0]         avs_byteenable_in,
  input wire logic [31:0]        avs_writedata_in,
  input wire logic [31:0]        avs_readdata_out,
  input wire logic               avs_waitrequest_out,
  // Core buses.
  input wire logic               prog_access_in,
  input wire abu_pkg::abu_addr_t prog_addr_in,
  input wire logic               data_access_in,
  input wire abu_pkg::abu_addr_t data_addr_in,
  // Interrupts.
  input wire logic               bp_aux_irq_out,
  input wire logic               irq_out
);
  // Bus decode: a request, its completing cycle and a hit-flag clear.
  wire       req  = avs_read_in | avs_write_in;
  wire       done = req & ~avs_waitrequest_out;
  wire [7:0] idx  = avs_address_in[9:2];
  wire       clr  = done & avs_write_in & avs_byteenable_in[0] & avs_writedata_in[7]
                    & (idx == `ABU_IDX_BREAKPOINT_CONTROL);
  wire       hit  = prog_access_in | data_access_in;

  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);

  // A request that is still waiting and is held into the next cycle.
  sequence s_held_wait;
    req && avs_waitrequest_out ##1 req;
  endsequence

  a_wait_first_cycle: assert property (req && !$past(req) |-> avs_waitrequest_out)
    else $error("waitrequest low in first request cycle");
  a_wait_one_cycle: assert property (s_held_wait |-> !avs_waitrequest_out)
    else $error("waitrequest longer than one cycle");
  a_read_upper_zero: assert property (done && avs_read_in |-> avs_readdata_out[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  a_unmapped_zero: assert property (done && avs_read_in && idx < 8'h95 |-> avs_readdata_out == 32'h0)
    else $error("unmapped read not zero");
  a_aux_has_cause: assert property ($rose(bp_aux_irq_out) |-> $past(hit))
    else $error("aux interrupt without core access");
  a_aux_stays_set: assert property (bp_aux_irq_out && !clr |=> bp_aux_irq_out)
    else $error("hit flag dropped without clear");
  a_irq_has_cause: assert property ($rose(irq_out) |-> $past(hit || (done && avs_write_in)))
    else $error("interrupt without event or mask write");
  a_irq_fall_bus: assert property ($fell(irq_out) |-> $past(done))
    else $error("interrupt dropped without bus access");
endmodule : abu_checker

bind abu_top abu_checker #(.ADDR_W(ADDR_W)) u_abu_checker (
  .clk_in, .reset_in, .avs_address_in, .avs_read_in, .avs_write_in, .avs_byteenable_in,
  .avs_writedata_in, .avs_readdata_out, .avs_waitrequest_out, .prog_access_in,
  .prog_addr_in, .data_access_in, .data_addr_in, .bp_aux_irq_out, .irq_out
);

`default_nettype wire

// file: test/abu_core_model.sv
// Core bus model: issues one-cycle program or data accesses on request.
// Assumes the bench calls its task and the unit samples strobes on rising edges.
`timescale 1ns/10ps
`default_nettype none

module abu_core_model (
  // Clock.
  input  wire logic               clk_in,
  // Core buses.
  output var logic                prog_access_out,
  output var abu_pkg::abu_addr_t  prog_addr_out,
  output var logic                data_access_out,
  output var abu_pkg::abu_addr_t  data_addr_out
);
  // Buses start idle on addresses that no test targets.
  initial begin
    prog_access_out = 1'b0;
    prog_addr_out   = 16'hFFFF;
    data_access_out = 1'b0;
    data_addr_out   = 16'h5AA5;
  end

  // One access; a prefetch drives the same strobe as a fetch.
  task automatic access(input logic prog, input abu_pkg::abu_addr_t addr);
    @(posedge clk_in);
    if (prog) begin
      prog_access_out <= 1'b1;
      prog_addr_out   <= addr;
    end else begin
      data_access_out <= 1'b1;
      data_addr_out   <= addr;
    end
    @(posedge clk_in);
    prog_access_out <= 1'b0;
    data_access_out <= 1'b0;
    prog_addr_out   <= ~addr;
    data_addr_out   <= ~addr;
  endtask : access
endmodule : abu_core_model

`default_nettype wire

// file: test/tb_top.sv
// Self-checking bench for the breakpoint unit.
// Assumes the checker is bound in and the core model drives the core buses.
`timescale 1ns/10ps
`default_nettype none
`include "abu_defines.svh"

module tb_top;
  localparam logic [7:0] IMC = `ABU_IDX_MEMORY_CONTROL;
  localparam logic [7:0] IBC = `ABU_IDX_BREAKPOINT_CONTROL;
  localparam logic [7:0] IAL = `ABU_IDX_BREAKPOINT_ADDRESS_LOW;
  localparam logic [7:0] IAH = `ABU_IDX_BREAKPOINT_ADDRESS_HIGH;
  localparam logic [7:0] IST = `ABU_IDX_IRQ_STATUS;
  localparam logic [7:0] IMK = `ABU_IDX_IRQ_MASK;

  logic               clk_in;
  logic               reset_in;
  logic [9:0]         avs_address_in;
  logic               avs_read_in;
  logic               avs_write_in;
  logic [3:0]         avs_byteenable_in;
  logic [31:0]        avs_writedata_in;
  logic [31:0]        avs_readdata_out;
  logic               avs_waitrequest_out;
  logic               prog_access_in;
  abu_pkg::abu_addr_t prog_addr_in;
  logic               data_access_in;
  abu_pkg::abu_addr_t data_addr_in;
  logic               bp_aux_irq_out;
  logic               irq_out;
  logic [3:0]         byte_en;
  int                 failures;
  int                 checks_done;

  abu_top u_abu_top (.clk_in, .reset_in, .avs_address_in, .avs_read_in, .avs_write_in,
    .avs_byteenable_in, .avs_writedata_in, .avs_readdata_out, .avs_waitrequest_out,
    .prog_access_in, .prog_addr_in, .data_access_in, .data_addr_in, .bp_aux_irq_out, .irq_out);
  abu_core_model u_abu_core_model (.clk_in, .prog_access_out(prog_access_in),
    .prog_addr_out(prog_addr_in), .data_access_out(data_access_in), .data_addr_out(data_addr_in));

  // Free-running 100 MHz clock.
  initial clk_in = 1'b0;
  always #5 clk_in = ~clk_in;

  // Prints the counts and the verdict, then stops.
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : final_report

  // Compares one value and counts it.
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // One Avalon transfer, held until waitrequest is seen low at a rising edge.
  task automatic xfer(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                      output logic [7:0] rd);
    logic w;
    int   n;
    n = 0;
    @(posedge clk_in);
    avs_read_in       <= ~wr;
    avs_write_in      <= wr;
    avs_address_in    <= {idx, 2'b00};
    avs_writedata_in  <= {24'h0, wd};
    avs_byteenable_in <= byte_en;
    do begin
      @(posedge clk_in);
      w  = avs_waitrequest_out;
      rd = avs_readdata_out[7:0];
      n++;
    end while (w !== 1'b0);
    check("wait cycles", 8'(n), 8'h02);
    avs_read_in  <= 1'b0;
    avs_write_in <= 1'b0;
  endtask : xfer

  // Register write and checked register read.
  task automatic wreg(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] x;
    xfer(1'b1, idx, d, x);
  endtask : wreg

  task automatic rchk(input string name, input logic [7:0] idx, input logic [7:0] exp);
    logic [7:0] x;
    xfer(1'b0, idx, 8'h00, x);
    check(name, x, exp);
  endtask : rchk

  // Core access, then the aux interrupt level one edge later.
  task automatic hit(input logic prog, input logic [15:0] a, input logic exp);
    u_abu_core_model.access(prog, a);
    @(negedge clk_in);
    check("aux irq", {7'h0, bp_aux_irq_out}, {7'h0, exp});
  endtask : hit

  // Reset values, unmapped place and a write with its byte lane off.
  task automatic t_reset();
    logic [7:0] regs [6] = '{IMC, IBC, IAL, IAH, IST, IMK};
    foreach (regs[i]) rchk("reset value", regs[i], 8'h00);
    wreg(8'h10, 8'hFF);
    rchk("unmapped", 8'h10, 8'h00);
    wreg(IMC, 8'h7F);
    rchk("storage bits", IMC, 8'h7F);
    byte_en = 4'h0;
    wreg(IBC, 8'h03);
    byte_en = 4'hF;
    rchk("lane off", IBC, 8'h00);
    $display("reset test done");
  endtask : t_reset

  // Program comparator set up in order, matched by a prefetch, then cleared.
  task automatic t_prog();
    wreg(IMC, 8'h00);
    wreg(IBC, 8'h02);
    wreg(IAL, 8'h34);
    wreg(IAH, 8'h12);
    wreg(IBC, 8'h03);
    rchk("control", IBC, 8'h03);
    rchk("addr low", IAL, 8'h34);
    rchk("addr high", IAH, 8'h12);
    wreg(IMC, 8'h80);
    rchk("other bank", IAL, 8'h00);
    hit(1'b0, 16'h1234, 1'b0);
    hit(1'b1, 16'h1235, 1'b0);
    hit(1'b1, 16'h1234, 1'b1);
    rchk("hit flag", IBC, 8'h83);
    rchk("fired select", IMC, 8'h00);
    wreg(IBC, 8'h03);
    rchk("zero write", IBC, 8'h83);
    wreg(IBC, 8'h83);
    rchk("cleared", IBC, 8'h03);
    $display("program test done");
  endtask : t_prog

  // Data comparator, both hits pending, selective clears and disable.
  task automatic t_data();
    wreg(IMC, 8'h80);
    wreg(IBC, 8'h00);
    wreg(IAL, 8'h01);
    wreg(IAH, 8'h80);
    wreg(IBC, 8'h01);
    hit(1'b1, 16'h8001, 1'b0);
    hit(1'b0, 16'h8001, 1'b1);
    rchk("fired select", IMC, 8'h80);
    hit(1'b1, 16'h1234, 1'b1);
    wreg(IMC, 8'h80);
    wreg(IBC, 8'h80);
    rchk("one left", IBC, 8'h80);
    wreg(IMC, 8'h00);
    wreg(IBC, 8'h83);
    rchk("none left", IBC, 8'h03);
    hit(1'b0, 16'h8001, 1'b0);
    $display("data test done");
  endtask : t_data

  // Sticky status, mask and read-clear of the interrupt output.
  task automatic t_irq();
    wreg(IMK, 8'h03);
    @(negedge clk_in);
    check("irq on", {7'h0, irq_out}, 8'h01);
    rchk("status", IST, 8'h03);
    @(negedge clk_in);
    check("irq off", {7'h0, irq_out}, 8'h00);
    rchk("status clear", IST, 8'h00);
    wreg(IMK, 8'h02);
    hit(1'b1, 16'h1234, 1'b1);
    check("irq masked", {7'h0, irq_out}, 8'h00);
    wreg(IMK, 8'h01);
    @(negedge clk_in);
    check("irq unmasked", {7'h0, irq_out}, 8'h01);
    rchk("status bit0", IST, 8'h01);
    $display("interrupt test done");
  endtask : t_irq

  // Reset, then the tests in order.
  initial begin
    failures          = 0;
    checks_done       = 0;
    byte_en           = 4'hF;
    reset_in          = 1'b1;
    avs_address_in    = 10'h000;
    avs_read_in       = 1'b0;
    avs_write_in      = 1'b0;
    avs_byteenable_in = 4'hF;
    avs_writedata_in  = 32'h0;
    repeat (5) @(posedge clk_in);
    reset_in <= 1'b0;
    t_reset();
    t_prog();
    t_data();
    t_irq();
    final_report();
  end

  // Cuts a hang short well after the tests should have ended.
  initial begin
    #100000;
    failures++;
    final_report();
  end
endmodule : tb_top

`default_nettype wire
